// ### logic/rtmi_pkg.sv
package rtmi_pkg;
    // ========================================
    // information word field positions
    localparam int RTMI_TMO_BIT = 15;
    localparam int RTMI_IWD_BIT = 14;
    localparam int RTMI_GAP_BIT = 13;
    localparam int RTMI_WCT_BIT = 12;
    localparam int RTMI_SYN_BIT = 11;
    localparam int RTMI_SUM_BIT = 10;
    localparam int RTMI_BUSY_BIT = 9;
    localparam int RTMI_ILL_BIT = 8;
    localparam int RTMI_TXRT_BIT = 7;
    localparam int RTMI_T2T_BIT = 6;
    localparam int RTMI_BUS_BIT = 5;
    localparam int RTMI_WC_LSB = 0;
    localparam int RTMI_WC_W = 5;
    // ========================================
    // command word layout
    localparam int RTMI_CW_ADDR_LSB = 11;
    localparam int RTMI_CW_TR_BIT = 10;
    localparam int RTMI_CW_SA_LSB = 5;
    localparam logic [4:0] RTMI_BCAST_ADDR = 5'h1f;
    localparam logic [4:0] RTMI_SA_MODE_LO = 5'h00;
    localparam logic [4:0] RTMI_SA_MODE_HI = 5'h1f;
    localparam logic [5:0] RTMI_WC_FULL = 6'h20;
    // ========================================
    // data structure offsets from the data pointer
    localparam logic [15:0] RTMI_OFS_INFO = 16'h0000;
    localparam logic [15:0] RTMI_OFS_TAG = 16'h0001;
    localparam logic [15:0] RTMI_OFS_DATA = 16'h0002;
    localparam logic [15:0] RTMI_WORD_RST = 16'h0000;
endpackage

// ### logic/rtmi_cw_check.sv
`timescale 1ns/1ps
// second command word and status word checks for an rt-rt receive
module rtmi_cw_check import rtmi_pkg::*; (
    // command words
    input wire logic [15:0] i_first_command_word,
    input wire logic [15:0] i_second_command_word,
    // status word from the transmitting terminal
    input wire logic [15:0] i_status_word,
    input wire logic i_status_ok,
    // results
    output logic o_second_bad,
    output logic o_status_bad
);
    logic [4:0] addr1;
    logic [4:0] addr2;
    logic [4:0] sa2;

    // field extraction
    assign addr1 = i_first_command_word[RTMI_CW_ADDR_LSB +: 5];
    assign addr2 = i_second_command_word[RTMI_CW_ADDR_LSB +: 5];
    assign sa2 = i_second_command_word[RTMI_CW_SA_LSB +: 5];

    // any of the five illegal second-word shapes
    assign o_second_bad = (addr2 == RTMI_BCAST_ADDR) //RULE1
        || !i_second_command_word[RTMI_CW_TR_BIT]
        || (sa2 == RTMI_SA_MODE_LO) || (sa2 == RTMI_SA_MODE_HI)
        || ((addr2 == addr1) && (addr1 != RTMI_BCAST_ADDR));

    // invalid status or answer from the wrong terminal
    assign o_status_bad = !i_status_ok //RULE2
        || (i_status_word[RTMI_CW_ADDR_LSB +: 5] != addr2);
endmodule

// ### logic/rtmi_info_word.sv
`timescale 1ns/1ps
// How it works
// RULE1 - bad second command word sets transmit_terminal_error
// RULE2 - bad or misaddressed status sets transmit_terminal_error
// RULE3 - receive bit 6 marks error-free rt-rt
// RULE4 - bit 5 zero bus A, one bus B
// RULE5 - bits 4-0 copy word count, zero 32
// RULE6 - host stages transmit data and pointer first
// RULE7 - host reserves two leading record words
// RULE8 - pointer: info word, time tag, then data
// RULE9 - config bit3 low: bit 13 gap error
// RULE10 - transmit bit 12 flags unexpected data words
// RULE11 - transmit bit 10 summarises bits 12, 13
// RULE12 - bit 9 busy answer, no data sent
// RULE13 - bit 8 copies illegalization table entry
// RULE14 - transmit bit 6 marks error-free rt-rt
// RULE15 - receive bit 7 holds transmit_terminal_error
// RULE16 - receive bit 10 summarises bits 7, 11-15
// RULE17 - config bit3 high: bit 13 broadcast flag
// RULE18 - transmit bits 15, 14, 11, 7 zero
module rtmi_info_word import rtmi_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // message framing
    input wire logic i_msg_start,
    input wire logic i_msg_done,
    input wire logic [15:0] i_first_command_word,
    input wire logic [15:0] i_data_pointer,
    input wire logic i_bus_select,
    input wire logic i_rt_to_rt,
    input wire logic i_broadcast,
    // rt-rt second command and status
    input wire logic i_second_word_valid,
    input wire logic [15:0] i_second_command_word,
    input wire logic i_status_valid,
    input wire logic [15:0] i_status_word,
    input wire logic i_status_ok,
    // error events, one-cycle pulses
    input wire logic i_gap_event,
    input wire logic i_count_event,
    input wire logic i_timeout_event,
    input wire logic i_invalid_word_event,
    input wire logic i_sync_event,
    // configuration and table bits
    input wire logic i_ext_cfg_bcast,
    input wire logic i_global_busy,
    input wire logic i_force_busy_bit,
    input wire logic i_illegal_entry,
    // results
    output logic [15:0] o_info_word,
    output logic o_info_write,
    output logic [15:0] o_info_addr,
    output logic [15:0] o_tag_addr,
    output logic [15:0] o_data_addr,
    output logic [5:0] o_data_words,
    output logic o_data_enable
);
    typedef enum logic [0:0] {
        RTMI_IDLE = 1'b0,
        RTMI_BUSY = 1'b1
    } rtmi_state_t;

    rtmi_state_t state_q;
    logic transmit_q;
    logic busy_q;
    logic [15:0] cmd_q;
    logic tmo_q, iwd_q, gap_q, wct_q, syn_q, txrt_q;
    logic tmo_d, iwd_d, gap_d, wct_d, syn_d, txrt_d;
    logic second_bad, status_bad;
    logic sum_d;
    logic [15:0] word_d;
    logic [4:0] wc;

    rtmi_cw_check u_check (
        .i_first_command_word(cmd_q),
        .i_second_command_word(i_second_command_word),
        .i_status_word(i_status_word),
        .i_status_ok(i_status_ok),
        .o_second_bad(second_bad),
        .o_status_bad(status_bad)
    );

    // ========================================
    // message framing
    // a new start inside a message restarts it; the old word is written only if done comes in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state_q <= RTMI_IDLE;
        end else if (i_msg_start) begin
            state_q <= RTMI_BUSY;
        end else begin
            case (state_q)
                RTMI_BUSY: begin
                    if (i_msg_done) begin
                        state_q <= RTMI_IDLE;
                    end
                end
                default: begin
                    state_q <= RTMI_IDLE;
                end
            endcase
        end
    end

    // command context latched at the command word
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cmd_q <= RTMI_WORD_RST;
            transmit_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (i_msg_start) begin
            cmd_q <= i_first_command_word;
            transmit_q <= i_first_command_word[RTMI_CW_TR_BIT];
            busy_q <= i_global_busy || i_force_busy_bit; //RULE12
        end
    end

    // ========================================
    // sticky error flags, an event in the closing cycle still counts
    always_comb begin
        tmo_d = tmo_q || i_timeout_event;
        iwd_d = iwd_q || i_invalid_word_event;
        gap_d = gap_q || (i_gap_event && !i_ext_cfg_bcast); //RULE9
        wct_d = wct_q || i_count_event; //RULE10
        syn_d = syn_q || i_sync_event;
        txrt_d = txrt_q
            || (i_second_word_valid && i_rt_to_rt && second_bad) //RULE1
            || (i_status_valid && i_rt_to_rt && status_bad); //RULE2
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || i_msg_start) begin
            {tmo_q, iwd_q, gap_q, wct_q, syn_q, txrt_q} <= 6'h00;
        end else if (state_q == RTMI_BUSY) begin
            {tmo_q, iwd_q, gap_q, wct_q, syn_q, txrt_q} <=
                {tmo_d, iwd_d, gap_d, wct_d, syn_d, txrt_d};
        end
    end

    // ========================================
    // word assembly
    assign wc = cmd_q[RTMI_WC_LSB +: RTMI_WC_W];

    always_comb begin
        word_d = RTMI_WORD_RST; // unused transmit bits stay zero RULE18
        if (transmit_q) begin
            sum_d = gap_d || wct_d; //RULE11
        end else begin
            sum_d = tmo_d || iwd_d || gap_d || wct_d || syn_d //RULE16
                || txrt_d;
            word_d[RTMI_TMO_BIT] = tmo_d;
            word_d[RTMI_IWD_BIT] = iwd_d;
            word_d[RTMI_SYN_BIT] = syn_d;
            word_d[RTMI_TXRT_BIT] = txrt_d; //RULE15
        end
        // bit 13 doubles as broadcast flag under the alternate config
        word_d[RTMI_GAP_BIT] = i_ext_cfg_bcast ? i_broadcast : gap_d; //RULE17
        word_d[RTMI_WCT_BIT] = wct_d; //RULE10
        word_d[RTMI_SUM_BIT] = sum_d;
        word_d[RTMI_BUSY_BIT] = busy_q; //RULE12
        word_d[RTMI_ILL_BIT] = i_illegal_entry; //RULE13
        word_d[RTMI_T2T_BIT] = i_rt_to_rt && !sum_d; //RULE3 RULE14
        word_d[RTMI_BUS_BIT] = i_bus_select; //RULE4
        word_d[RTMI_WC_LSB +: RTMI_WC_W] = wc; //RULE5
    end

    // write strobe and word, one cycle after the done pulse
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_info_word <= RTMI_WORD_RST;
            o_info_write <= 1'b0;
        end else begin
            o_info_write <= i_msg_done && (state_q == RTMI_BUSY);
            if (i_msg_done && (state_q == RTMI_BUSY)) begin
                o_info_word <= word_d;
            end
        end
    end

    // ========================================
    // record layout; the host must have staged data beforehand
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_info_addr <= RTMI_WORD_RST;
            o_tag_addr <= RTMI_WORD_RST;
            o_data_addr <= RTMI_WORD_RST;
        end else if (i_msg_start) begin
            o_info_addr <= i_data_pointer + RTMI_OFS_INFO; //RULE8
            o_tag_addr <= i_data_pointer + RTMI_OFS_TAG;
            o_data_addr <= i_data_pointer + RTMI_OFS_DATA; //RULE7
        end
    end

    // data word total and transmit data gate
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_data_words <= 6'h00;
            o_data_enable <= 1'b0;
        end else if (i_msg_start) begin
            o_data_words <= (i_first_command_word[4:0] == 5'h00) ?
                RTMI_WC_FULL : {1'b0, i_first_command_word[4:0]}; //RULE5
            o_data_enable <= i_first_command_word[RTMI_CW_TR_BIT]
                && !(i_global_busy || i_force_busy_bit); //RULE12 RULE6
        end else if (i_msg_done) begin
            o_data_enable <= 1'b0;
        end
    end

    // ========================================
    // checks
    property p_write_follows_done;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_msg_done && state_q == RTMI_BUSY) |=> o_info_write;
    endproperty
    a_write_follows_done: assert property (p_write_follows_done) //RULE8
        else $error("info word not written after done");

    property p_bus_bit;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_msg_done && state_q == RTMI_BUSY)
            |=> o_info_word[RTMI_BUS_BIT] == $past(i_bus_select);
    endproperty
    a_bus_bit: assert property (p_bus_bit) //RULE4
        else $error("bus bit mismatch");

    property p_wc_copy;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_info_write |-> o_info_word[4:0] == cmd_q[4:0];
    endproperty
    a_wc_copy: assert property (p_wc_copy) //RULE5
        else $error("word count field mismatch");

    property p_tx_unused_zero;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (o_info_write && transmit_q) |-> (o_info_word[15] == 1'b0
            && o_info_word[14] == 1'b0 && o_info_word[11] == 1'b0
            && o_info_word[7] == 1'b0);
    endproperty
    a_tx_unused_zero: assert property (p_tx_unused_zero) //RULE18
        else $error("unused transmit bits set");

    property p_tx_summary;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (o_info_write && transmit_q) |-> o_info_word[RTMI_SUM_BIT]
            == (wct_q || (o_info_word[RTMI_GAP_BIT] && !i_ext_cfg_bcast));
    endproperty
    a_tx_summary: assert property (p_tx_summary) //RULE11
        else $error("transmit summary bit wrong");

    // the flag must follow the rt-rt input, not only avoid errors
    property p_t2t_clean;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_info_write |-> o_info_word[RTMI_T2T_BIT]
            == ($past(i_rt_to_rt) && !o_info_word[RTMI_SUM_BIT]);
    endproperty
    a_t2t_clean: assert property (p_t2t_clean) //RULE3
        else $error("rt-rt flag disagrees with errors");

    property p_busy_no_data;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_msg_start && (i_global_busy || i_force_busy_bit))
            |=> !o_data_enable;
    endproperty
    a_busy_no_data: assert property (p_busy_no_data) //RULE12
        else $error("data enabled while busy");

    property p_second_error;
        @(posedge i_core_clk) disable iff (i_sys_rst || i_msg_start)
        (state_q == RTMI_BUSY && i_second_word_valid && i_rt_to_rt
            && second_bad) |=> txrt_q;
    endproperty
    a_second_error: assert property (p_second_error) //RULE1
        else $error("bad second command not flagged");

    property p_rx_summary;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (o_info_write && !transmit_q && o_info_word[RTMI_TXRT_BIT])
            |-> o_info_word[RTMI_SUM_BIT];
    endproperty
    a_rx_summary: assert property (p_rx_summary) //RULE16
        else $error("receive summary bit missing");

    property p_tag_addr;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        i_msg_start |=> o_tag_addr == $past(i_data_pointer) + RTMI_OFS_TAG;
    endproperty
    a_tag_addr: assert property (p_tag_addr) //RULE8
        else $error("time tag address wrong");
endmodule

// ### sim/rtmi_host_model.sv
`timescale 1ns/1ps
// ========================================
// host side: owns the shared ram and keeps the device results
module rtmi_host_model (
    // clock
    input wire logic i_core_clk,
    // info word write from the device
    input wire logic i_info_write,
    input wire logic [15:0] i_info_addr,
    input wire logic [15:0] i_info_word
);
    logic [15:0] mem [0:255];

    // only the low byte is decoded, a small window is enough here
    always @(posedge i_core_clk) begin
        if (i_info_write) begin
            mem[i_info_addr[7:0]] <= i_info_word;
        end
    end

    // stage a record; the two leading words hold junk so a missed write shows
    task automatic stage(input logic [15:0] ptr, input int n);
        mem[ptr[7:0]] = 16'hdead;
        mem[ptr[7:0] + 8'h01] = 16'hdead;
        for (int k = 0; k < n; k++) begin
            mem[ptr[7:0] + 8'h02 + k[7:0]] = ptr ^ k[15:0];
        end
    endtask
endmodule

// ### sim/rtmi_info_word_tb_top.sv
`timescale 1ns/1ps
// ========================================
// bench for the message information word builder
module rtmi_info_word_tb_top;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_msg_start = 1'b0;
    logic i_msg_done = 1'b0;
    logic [15:0] i_first_command_word = 16'h0000;
    logic [15:0] i_data_pointer = 16'h0000;
    logic [15:0] i_second_command_word = 16'h0000;
    logic [15:0] i_status_word = 16'h0000;
    logic i_bus_select, i_rt_to_rt, i_broadcast, i_second_word_valid;
    logic i_status_valid, i_status_ok, i_gap_event, i_count_event;
    logic i_timeout_event, i_invalid_word_event, i_sync_event;
    logic i_ext_cfg_bcast, i_global_busy, i_force_busy_bit, i_illegal_entry;
    logic [15:0] o_info_word, o_info_addr, o_tag_addr, o_data_addr;
    logic [5:0] o_data_words;
    logic o_info_write, o_data_enable;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // each bad second word gets a matching status so only its own check trips
    logic [15:0] bsec [5] = '{16'hfc80, 16'h2880, 16'h2c00, 16'h2fe0,
        16'h1c80};
    logic [15:0] bsts [5] = '{16'hf800, 16'h2800, 16'h2800, 16'h2800,
        16'h1800};

    always #5 i_core_clk = ~i_core_clk;

    rtmi_info_word DUT (.*);
    rtmi_host_model host (.i_core_clk(i_core_clk),
        .i_info_write(o_info_write), .i_info_addr(o_info_addr),
        .i_info_word(o_info_word));

    task automatic summarize();
        if (err_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // a hang costs one mismatch and ends the run
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            err_count++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // ev: gap count tmo iwd syn sec sts; fl: ok ext bcast gb fb ill bus t2t
    function automatic logic [15:0] exp_word(input logic [15:0] c1,
            input logic [15:0] c2, input logic [15:0] st,
            input logic [6:0] ev, input logic [7:0] fl);
        logic [15:0] w;
        logic bad;
        w = 16'h0000;
        bad = (c2[15:11] == 5'h1f) | ~c2[10] | (c2[9:5] == 5'h00)
            | (c2[9:5] == 5'h1f)
            | ((c2[15:11] == c1[15:11]) & (c1[15:11] != 5'h1f))
            | ~fl[7] | (st[15:11] != c2[15:11]);
        bad = bad & fl[0] & ev[1] & ~c1[10];
        w[13] = fl[6] ? fl[5] : ev[6];
        w[12] = ev[5];
        if (!c1[10]) {w[15], w[14], w[11], w[7]} = {ev[4:2], bad};
        w[10] = |{w[15:14], w[12:11], w[7], ev[6] & ~fl[6]};
        w[9] = fl[4] | fl[3];
        w[8] = fl[2];
        w[6] = fl[0] & ~w[10];
        w[5] = fl[1];
        w[4:0] = c1[4:0];
        return w;
    endfunction

    // one whole message: start, events, done, then the stored word
    task automatic run(input logic [15:0] c1, input logic [15:0] c2,
            input logic [15:0] st, input logic [6:0] ev,
            input logic [7:0] fl);
        logic [15:0] ptr;
        logic [15:0] exp;
        logic de;
        logic [15:0] nw;
        ptr = 16'h1200 | {8'h00, c1[4:0], 3'h0};
        exp = exp_word(c1, c2, st, ev, fl);
        de = c1[10] & ~(fl[4] | fl[3]);
        nw = (c1[4:0] == 5'h00) ? 16'h0020 : {11'h000, c1[4:0]};
        host.stage(ptr, 32);
        i_first_command_word = c1;
        i_data_pointer = ptr;
        i_second_command_word = c2;
        i_status_word = st;
        {i_status_ok, i_ext_cfg_bcast, i_broadcast, i_global_busy,
            i_force_busy_bit, i_illegal_entry, i_bus_select, i_rt_to_rt} = fl;
        i_msg_start = 1'b1;
        @(negedge i_core_clk);
        i_msg_start = 1'b0;
        {i_gap_event, i_count_event, i_timeout_event, i_invalid_word_event,
            i_sync_event, i_second_word_valid, i_status_valid} = ev;
        @(negedge i_core_clk);
        {i_gap_event, i_count_event, i_timeout_event, i_invalid_word_event,
            i_sync_event, i_second_word_valid, i_status_valid} = 7'h00;
        chk(o_info_addr, ptr);
        chk(o_data_addr, ptr + 16'h0002);
        chk(o_tag_addr, ptr + 16'h0001);
        chk({10'h000, o_data_words}, nw);
        chk({15'h0000, o_data_enable}, {15'h0000, de});
        if (de) chk(host.mem[o_data_addr[7:0]], ptr);
        i_msg_done = 1'b1;
        @(negedge i_core_clk);
        i_msg_done = 1'b0;
        chk({15'h0000, o_info_write}, 16'h0001);
        chk(o_info_word, exp);
        chk({15'h0000, o_data_enable}, 16'h0000);
        @(negedge i_core_clk);
        chk(host.mem[ptr[7:0]], exp);
        chk({15'h0000, o_info_write}, 16'h0000);
    endtask

    initial begin
        {i_bus_select, i_rt_to_rt, i_broadcast, i_second_word_valid,
            i_status_valid, i_status_ok, i_gap_event, i_count_event,
            i_timeout_event, i_invalid_word_event, i_sync_event,
            i_ext_cfg_bcast, i_global_busy, i_force_busy_bit,
            i_illegal_entry} = '0;
        repeat (5) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        chk(o_info_word, 16'h0000);
        // a done with no message open must not write
        i_msg_done = 1'b1;
        @(negedge i_core_clk);
        i_msg_done = 1'b0;
        chk({15'h0000, o_info_write}, 16'h0000);
        run(16'h1840, 16'h2c80, 16'h2800, 7'h03, 8'h83);
        for (int i = 0; i < 5; i++) begin
            run(16'h1845, bsec[i], bsts[i], 7'h03, 8'h81);
        end
        run(16'h1841, 16'h2c80, 16'h2800, 7'h03, 8'h01);
        run(16'h1841, 16'h2c80, 16'h3000, 7'h03, 8'h81);
        run(16'h185f, 16'h0000, 16'h0000, 7'h3c, 8'h82);
        run(16'h1c43, 16'h0000, 16'h0000, 7'h40, 8'h80);
        run(16'h1c5f, 16'h0000, 16'h0000, 7'h3c, 8'h80);
        run(16'h1c44, 16'h0000, 16'h0000, 7'h00, 8'he0);
        run(16'h1843, 16'h0000, 16'h0000, 7'h40, 8'hc0);
        run(16'h1c41, 16'h0000, 16'h0000, 7'h00, 8'h90);
        run(16'h1c41, 16'h0000, 16'h0000, 7'h00, 8'h88);
        run(16'h1c42, 16'h0000, 16'h0000, 7'h00, 8'h84);
        run(16'h1c42, 16'h0000, 16'h0000, 7'h00, 8'h81);
        summarize();
    end
endmodule
